// ===== fsia_defines.svh
`ifndef FSIA_DEFINES_SVH
`define FSIA_DEFINES_SVH

// register offsets on the local register port
`define ADDR_FORWARD_SYNC_STATUS 8'h22
`define ADDR_IRQ_ENABLE_CONTROL 8'h23
`define ADDR_IRQ_PENDING_STATUS 8'h24

// reset and idle values
`define BYTE_ZERO 8'h00
`define IEC_RESET 8'h00

// writable bits of the enable register
`define IEC_WMASK 8'hBF

// field positions
`define BIT_GLOBAL_EN 7
`define BIT_GLOBAL_PEND 7
`define BIT_OUT1_FAIL 3
`define BIT_OUT0_FAIL 2
`define BIT_OUT1_SYNC 1
`define BIT_OUT0_SYNC 0
`define SRC_EN_MSB 5
`define BIT_IEC_RSVD 6

// reserved upper nibble of the forward status register, reserved bit six of the pending register
`define FS_RSVD_MASK 8'hF0
`define IPS_RSVD_MASK 8'h40

// synchronized forwarding mode codes
`define MODE_DISABLED 2'h0
`define MODE_BASIC 2'h1
`define MODE_INTERLEAVE 2'h2
`define MODE_CONCAT 2'h3

`endif

// ===== fsia_pkg.sv
package fsia_pkg;
   typedef logic [1:0] sync_mode_t;
   typedef logic [7:0] reg_byte_t;
   typedef enum {TRK_OFF, TRK_ARMING, TRK_PROVEN} trk_state_t;
endpackage

// ===== fsia_if.sv
`timescale 1ns/1ns
// one output's forwarding tracker and its owner
interface trk_if;
   import fsia_pkg::*;
   sync_mode_t mode;
   logic locked;
   logic frame_ok;
   logic loss;
   logic rd_clr;
   logic ind;
   logic fail;
   modport tracker(input mode, locked, frame_ok, loss, rd_clr,
      output ind, fail);
   modport owner(output mode, locked, frame_ok, loss, rd_clr,
      input ind, fail);
endinterface

// a bank of sticky event flags
interface flag_if #(parameter int N = 2);
   logic [N-1:0] set;
   logic [N-1:0] clr;
   logic [N-1:0] flags;
   modport bank(input set, clr, output flags);
   modport owner(output set, clr, input flags);
endinterface

// ===== sync_tracker.sv
`timescale 1ns/1ns
`include "fsia_defines.svh"
module sync_tracker (
   input wire logic clk,
   input wire logic arst_n,
   trk_if.tracker t
);
   import fsia_pkg::*;

   trk_state_t st_q, st_d;
   logic fail_q, fail_d, ind_q;
   wire off = (t.mode == `MODE_DISABLED);
   wire proven_loss = (st_q == TRK_PROVEN) && t.loss && !off;

   // armed only once a synchronized frame went out
   always_comb
   begin
      st_d = st_q;
      unique case (st_q)
         TRK_OFF: if (!off) st_d = TRK_ARMING;
         TRK_ARMING:
            if (off) st_d = TRK_OFF;
            else if (t.frame_ok) st_d = TRK_PROVEN;
         TRK_PROVEN:
            if (off) st_d = TRK_OFF;
            else if (t.loss) st_d = TRK_ARMING;
      endcase
   end

   // sticky failure, set wins over read clear
   assign fail_d = proven_loss | (fail_q & ~t.rd_clr);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_q <= TRK_OFF;
         fail_q <= 1'b0;
         ind_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         fail_q <= fail_d;
         ind_q <= t.locked & ~off;
      end
   end

   assign t.fail = fail_q;
   assign t.ind = ind_q;

   sequence s_proven_loss;
      (st_q == TRK_PROVEN) && t.loss && !off;
   endsequence

   AST_FAIL_RAISE: assert property (@(posedge clk)
      disable iff (!arst_n) s_proven_loss |=> t.fail)
      else $error("failure flag not raised on loss");
   AST_FAIL_NEEDS_FRAME: assert property (@(posedge clk)
      disable iff (!arst_n)
      $rose(t.fail) |-> $past(st_q) == TRK_PROVEN)
      else $error("failure flag set before a good frame");
   AST_IND_OFF: assert property (@(posedge clk) disable iff (!arst_n)
      off |=> !t.ind)
      else $error("indicator high while forwarding disabled");
endmodule

// ===== event_flag_bank.sv
`timescale 1ns/1ns
module event_flag_bank #(
   parameter int N = 2
) (
   input wire logic clk,
   input wire logic arst_n,
   flag_if.bank b
);
   import fsia_pkg::*;

   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_bit
         logic f_q;
         // sticky flag, a new event beats a clear
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
               f_q <= 1'b0;
            else
               f_q <= b.set[g] | (f_q & ~b.clr[g]);
         end
         assign b.flags[g] = f_q;

         AST_SET_WINS: assert property (@(posedge clk)
            disable iff (!arst_n) b.set[g] |=> b.flags[g])
            else $error("event lost against clear");
      end
   endgenerate
endmodule

// ===== forwarding_status_irq_aggregator.sv
`timescale 1ns/1ns
`include "fsia_defines.svh"
// Contract
// - failure flag per output on sync loss
// - failure only after one good frame
// - status read clears failure flags, sticky otherwise
// - sync indicator follows engine lock state
// - indicator low when forwarding disabled
// - global interrupt enable at bit seven
// - transmit port enables at bits five, four
// - receive port enables bits three to zero
// - global pending when enabled source pending
// - global pending ignores global enable
// - transmit pending cleared by its status read
// - receive pending cleared by causing status reads
// - two-bit mode, zero disables forwarding
module forwarding_status_irq_aggregator (
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire logic [7:0] ADDR,
   input wire fsia_pkg::reg_byte_t WDATA,
   input wire logic WR,
   input wire logic RD,
   output fsia_pkg::reg_byte_t RDATA,
   input wire fsia_pkg::sync_mode_t SYNC_MODE0,
   input wire fsia_pkg::sync_mode_t SYNC_MODE1,
   input wire logic [1:0] ENG_LOCKED,
   input wire logic [1:0] ENG_FRAME_OK,
   input wire logic [1:0] ENG_SYNC_LOSS,
   input wire logic [1:0] TX_EVENT,
   input wire logic [1:0] TX_STATUS_RD,
   input wire logic [3:0] RX_EVT_FIRST,
   input wire logic [3:0] RX_EVT_SECOND,
   input wire logic [3:0] RX_EVT_VIDEO,
   input wire logic [3:0] RX_RD_FIRST,
   input wire logic [3:0] RX_RD_SECOND,
   input wire logic [3:0] RX_RD_VIDEO,
   output logic IRQ
);
   import fsia_pkg::*;

   localparam int NOUT = 2;
   localparam int NTX = 2;
   localparam int NRX = 4;

   reg_byte_t iec_q;
   reg_byte_t rdata_q;
   logic irq_q;
   logic [NOUT-1:0] trk_ind;
   logic [NOUT-1:0] trk_fail;
   logic [NRX-1:0] rx_pend;
   logic [NTX-1:0] tx_pend;

   // address decode
   wire sel_fs = (ADDR == `ADDR_FORWARD_SYNC_STATUS);
   wire sel_iec = (ADDR == `ADDR_IRQ_ENABLE_CONTROL);
   wire sel_ips = (ADDR == `ADDR_IRQ_PENDING_STATUS);
   wire rd_fs = RD & sel_fs;
   wire rd_ips = RD & sel_ips;
   wire wr_iec = WR & sel_iec;

   // one tracker per video output
   genvar g;
   generate
      for (g = 0; g < NOUT; g++)
      begin : g_out
         trk_if t ();
         assign t.mode = (g == 0) ? SYNC_MODE0 : SYNC_MODE1;
         assign t.locked = ENG_LOCKED[g];
         assign t.frame_ok = ENG_FRAME_OK[g];
         assign t.loss = ENG_SYNC_LOSS[g];
         assign t.rd_clr = rd_fs;
         assign trk_ind[g] = t.ind;
         assign trk_fail[g] = t.fail;
         sync_tracker u_trk (
            .clk(MCLK),
            .arst_n(ARST_N),
            .t(t)
         );
      end
   endgenerate

   // transmit port pending flags
   flag_if #(.N(NTX)) txf ();
   assign txf.set = TX_EVENT;
   assign txf.clr = TX_STATUS_RD;
   assign tx_pend = txf.flags;

   event_flag_bank #(.N(NTX)) u_tx_bank (
      .clk(MCLK),
      .arst_n(ARST_N),
      .b(txf)
   );

   // receive flags: first, second and video groups per port
   flag_if #(.N(3 * NRX)) rxf ();
   assign rxf.set = {RX_EVT_VIDEO, RX_EVT_SECOND, RX_EVT_FIRST};
   assign rxf.clr = {RX_RD_VIDEO, RX_RD_SECOND, RX_RD_FIRST};

   event_flag_bank #(.N(3 * NRX)) u_rx_bank (
      .clk(MCLK),
      .arst_n(ARST_N),
      .b(rxf)
   );

   // port pending while any of its groups holds an event
   generate
      for (g = 0; g < NRX; g++)
      begin : g_rx
         assign rx_pend[g] = rxf.flags[g] | rxf.flags[NRX + g]
            | rxf.flags[2 * NRX + g];
      end
   endgenerate

   // source vector, enables and global pending
   wire [5:0] src_w = {tx_pend, rx_pend};
   wire [5:0] en_w = iec_q[`SRC_EN_MSB:0];
   wire global_en = iec_q[`BIT_GLOBAL_EN];
   wire gpend = |(src_w & en_w);
   wire irq_cause = global_en & gpend;

   // status words as software sees them
   wire [7:0] fs_word = {4'h0, trk_fail[1], trk_fail[0],
      trk_ind[1], trk_ind[0]};
   wire [7:0] ips_word = {gpend, 1'b0, src_w};

   // read selection, unmapped reads return zero
   wire [7:0] rd_mux = sel_fs ? fs_word :
      sel_iec ? iec_q :
      sel_ips ? ips_word : `BYTE_ZERO;

   // enable register, reserved bit never stored
   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         iec_q <= `IEC_RESET;
      else if (wr_iec)
         iec_q <= WDATA & `IEC_WMASK;
   end

   // read data for exactly one cycle after the strobe
   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         rdata_q <= `BYTE_ZERO;
      else if (RD)
         rdata_q <= rd_mux;
      else
         rdata_q <= `BYTE_ZERO;
   end

   // interrupt line toward the host
   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         irq_q <= 1'b0;
      else
         irq_q <= irq_cause;
   end

   assign RDATA = rdata_q;
   assign IRQ = irq_q;

   // sequences shared by the checks below
   sequence s_fs_read;
      RD && sel_fs;
   endsequence

   sequence s_ips_read;
      RD && sel_ips;
   endsequence

   sequence s_iec_write;
      WR && sel_iec;
   endsequence

   sequence s_rx0_drain;
      RX_RD_FIRST[0] && RX_RD_SECOND[0] && RX_RD_VIDEO[0]
         && !RX_EVT_FIRST[0] && !RX_EVT_SECOND[0] && !RX_EVT_VIDEO[0];
   endsequence

   sequence s_fail0_held;
      trk_fail[0] && !rd_fs;
   endsequence

   sequence s_fail1_held;
      trk_fail[1] && !rd_fs;
   endsequence

   sequence s_iec_read;
      RD && sel_iec;
   endsequence

   sequence s_unmapped_read;
      RD && !sel_fs && !sel_iec && !sel_ips;
   endsequence

   AST_FAIL_CLEARED: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      s_fs_read ##0 !ENG_SYNC_LOSS[0] |=> !trk_fail[0])
      else $error("failure flag survived status read");

   AST_FAIL_STICKY: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      s_fail0_held |=> trk_fail[0])
      else $error("failure flag dropped without a read");

   AST_FS_READBACK: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      s_fs_read |=> (RDATA == $past(fs_word))
         && ((RDATA & `FS_RSVD_MASK) == `BYTE_ZERO))
      else $error("forward status read data wrong");

   AST_IND_FOLLOWS: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      (ENG_LOCKED[1] && SYNC_MODE1 != `MODE_DISABLED)
         |=> trk_ind[1] ##1 1'b1)
      else $error("indicator missed engine lock");

   AST_IEC_WRITE: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      s_iec_write ##1 RD && sel_iec
         |=> RDATA == ($past(WDATA, 2) & `IEC_WMASK))
      else $error("enable register readback wrong");

   AST_IEC_HOLD: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      !wr_iec |=> iec_q == $past(iec_q))
      else $error("enable register changed without write");

   AST_GPEND: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      s_ips_read ##0 (src_w[0] && en_w[0] && !global_en)
         |=> RDATA[`BIT_GLOBAL_PEND])
      else $error("global pending depends on global enable");

   AST_PEND_RSVD: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      s_ips_read |=> (RDATA & `IPS_RSVD_MASK) == `BYTE_ZERO)
      else $error("reserved pending bit reads one");

   AST_IRQ: assert property (@(posedge MCLK) disable iff (!ARST_N)
      IRQ == $past(irq_cause))
      else $error("interrupt line disagrees with enable and pending");

   AST_IRQ_MASKED: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      !global_en [*2] |-> !IRQ)
      else $error("interrupt raised with global enable off");

   AST_TX_CLR: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      TX_STATUS_RD[1] && !TX_EVENT[1] |=> !tx_pend[1])
      else $error("transmit pending not cleared by its read");

   AST_RX_CLR: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      s_rx0_drain |=> !rx_pend[0])
      else $error("receive pending not cleared by status reads");

   AST_RX_PARTIAL: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      rxf.flags[2 * NRX + 2] && RX_RD_FIRST[2] && !RX_RD_VIDEO[2]
         |=> rx_pend[2])
      else $error("receive pending cleared by wrong read");

   AST_RDATA_IDLE: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      !RD |=> RDATA == `BYTE_ZERO)
      else $error("read data outside read slot");

   // second output's failure flag, same read-clear contract
   AST_FAIL1_CLEARED: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      s_fs_read ##0 !ENG_SYNC_LOSS[1] |=> !trk_fail[1])
      else $error("second failure flag survived status read");

   AST_FAIL1_STICKY: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      s_fail1_held |=> trk_fail[1])
      else $error("second failure flag dropped without a read");

   // indicators track lock and mode of their own output
   AST_IND0_FOLLOWS: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      (ENG_LOCKED[0] && SYNC_MODE0 != `MODE_DISABLED) |=> trk_ind[0])
      else $error("first indicator missed engine lock");

   AST_IND_DROPS: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      !ENG_LOCKED[0] |=> !trk_ind[0])
      else $error("indicator high without engine lock");

   AST_IND_MODE_OFF: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      (SYNC_MODE1 == `MODE_DISABLED) |=> !trk_ind[1])
      else $error("indicator high with forwarding off");

   // pending flags hold until their own reads
   AST_TX0_CLR: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      TX_STATUS_RD[0] && !TX_EVENT[0] |=> !tx_pend[0])
      else $error("transmit pending not cleared by its read");

   AST_TX_HOLD: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      tx_pend[0] && !TX_STATUS_RD[0] |=> tx_pend[0])
      else $error("transmit pending dropped without a read");

   AST_RX_SET: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      RX_EVT_FIRST[3] |=> rx_pend[3])
      else $error("receive pending missed an event");

   AST_RX_GROUP_HOLD: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      rxf.flags[NRX + 1] && !RX_RD_SECOND[1] |=> rx_pend[1])
      else $error("receive pending dropped before its read");

   // register reads return what the registers hold
   AST_IEC_RSVD: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      iec_q[`BIT_IEC_RSVD] == 1'b0)
      else $error("reserved enable bit stored");

   AST_IEC_READBACK: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      s_iec_read |=> RDATA == $past(iec_q))
      else $error("enable register read data wrong");

   AST_IPS_READBACK: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      s_ips_read |=> RDATA == $past(ips_word))
      else $error("pending register read data wrong");

   AST_GPEND_ZERO: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      s_ips_read ##0 ((src_w & en_w) == 6'h00)
         |=> !RDATA[`BIT_GLOBAL_PEND])
      else $error("global pending without an enabled source");

   AST_RDATA_UNMAPPED: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      s_unmapped_read |=> RDATA == `BYTE_ZERO)
      else $error("unmapped read returned data");
endmodule

// ===== host_model.sv
`timescale 1ns/1ns
// host side: register port master and status readers
module host_model (
   input wire logic clk,
   output logic [7:0] addr,
   output fsia_pkg::reg_byte_t wdata,
   output logic wr,
   output logic rd,
   input wire fsia_pkg::reg_byte_t rdata,
   output logic [1:0] tx_rd,
   output logic [3:0] rd_first,
   output logic [3:0] rd_second,
   output logic [3:0] rd_video
);
   import fsia_pkg::*;
   // idle bus at time zero
   initial
   begin
      {addr, wdata, wr, rd} = '0;
      {tx_rd, rd_first, rd_second, rd_video} = '0;
   end
   // one-cycle write strobe
   task automatic wr_reg(input logic [7:0] a, input reg_byte_t d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // write, then read back in the very next cycle
   task automatic wr_rd(input logic [7:0] a, input reg_byte_t d,
      output reg_byte_t q);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      q = rdata;
   endtask
   // read strobe, data taken in the cycle after
   task automatic rd_reg(input logic [7:0] a, output reg_byte_t d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   // reads of the recording status registers
   task automatic clr(input logic [1:0] t, input logic [3:0] a, b, c);
      @(posedge clk);
      tx_rd <= t;
      rd_first <= a;
      rd_second <= b;
      rd_video <= c;
      @(posedge clk);
      {tx_rd, rd_first, rd_second, rd_video} <= '0;
   endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb;
   import fsia_pkg::*;
   logic mclk, arst_n, wr, rd, irq;
   logic [7:0] addr;
   reg_byte_t wdata, rdata, got;
   sync_mode_t mode0, mode1;
   logic [1:0] locked, frame_ok, loss, tx_ev, tx_rd;
   logic [3:0] ev1, ev2, evv, rd1, rd2, rdv;
   int n_errors, checks_done, en, txp, v, tmp;
   int rxg[4];
   // clock and watchdog
   always #4 mclk = ~mclk;
   initial
   begin
      #100000;
      n_errors++;
      print_verdict();
   end
   forwarding_status_irq_aggregator DUT (.MCLK(mclk), .ARST_N(arst_n),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .SYNC_MODE0(mode0), .SYNC_MODE1(mode1), .ENG_LOCKED(locked),
      .ENG_FRAME_OK(frame_ok), .ENG_SYNC_LOSS(loss), .TX_EVENT(tx_ev),
      .TX_STATUS_RD(tx_rd), .RX_EVT_FIRST(ev1), .RX_EVT_SECOND(ev2),
      .RX_EVT_VIDEO(evv), .RX_RD_FIRST(rd1), .RX_RD_SECOND(rd2),
      .RX_RD_VIDEO(rdv), .IRQ(irq));
   host_model HOST (.clk(mclk), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .tx_rd(tx_rd), .rd_first(rd1),
      .rd_second(rd2), .rd_video(rdv));
   // expected status of the pending register
   function automatic int pend();
      int p = txp * 16;
      for (int i = 0; i < 4; i++)
         p += int'(rxg[i] != 0) << i;
      return int'((p & en & 'h3F) != 0) * 128 + p;
   endfunction
   // expected forwarding status without failures
   function automatic int st22();
      return int'(locked[1] && mode1 != 0) * 2 + int'(locked[0] && mode0 != 0);
   endfunction
   task automatic chk(input logic [7:0] a, input int e);
      HOST.rd_reg(a, got);
      `CHK(got, e[7:0])
   endtask
   task automatic chkp();
      chk(8'h24, pend());
      tmp = pend();
      `CHK(irq, en[7] & tmp[7])
   endtask
   // end event pulses
   task automatic step();
      @(posedge mclk);
      {frame_ok, loss, tx_ev, ev1, ev2, evv} <= '0;
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // main sequence
   initial
   begin
      {mclk, arst_n, mode0, mode1, locked} = '0;
      {frame_ok, loss, tx_ev, ev1, ev2, evv} = '0;
      {n_errors, checks_done, en, txp} = '0;
      rxg = '{0, 0, 0, 0};
      void'($urandom(11));
      repeat (6) @(posedge mclk);
      arst_n <= 1'b1;
      chk(8'h22, 0);
      chk(8'h23, 0);
      chk(8'h24, 0);
      $display("test reset values done");
      HOST.wr_rd(8'h23, 8'hFF, got);
      en = 'hBF;
      `CHK(got, en[7:0])
      repeat (4)
      begin
         v = $urandom;
         HOST.wr_reg(8'h23, v[7:0]);
         HOST.wr_reg(8'h22, 8'hFF);
         HOST.wr_reg(8'h24, 8'hFF);
         en = v & 'hBF;
         chk(8'h23, en);
         chk(8'h22, 0);
         chk(8'h25, 0);
      end
      $display("test enable register done");
      @(posedge mclk);
      mode0 <= 2'h1;
      mode1 <= 2'h2;
      locked <= 2'b00;
      @(posedge mclk);
      loss <= 2'b11;
      step();
      chk(8'h22, 0);
      @(posedge mclk);
      frame_ok <= 2'b11;
      step();
      @(posedge mclk);
      loss <= 2'b01;
      step();
      repeat (5) @(posedge mclk);
      chk(8'h22, 4);
      chk(8'h22, 0);
      @(posedge mclk);
      loss <= 2'b11;
      step();
      chk(8'h22, 8);
      chk(8'h22, 0);
      $display("test sync failure done");
      for (int m = 0; m < 4; m++)
      begin
         v = $urandom;
         @(posedge mclk);
         mode0 <= 2'(m);
         mode1 <= 2'(3 - m);
         locked <= v[1:0];
         repeat (3) @(posedge mclk);
         chk(8'h22, st22());
         @(posedge mclk);
         locked <= 2'b11;
         repeat (3) @(posedge mclk);
         chk(8'h22, st22());
      end
      $display("test sync indicator done");
      repeat (12)
      begin
         v = $urandom;
         HOST.wr_reg(8'h23, v[7:0]);
         en = v & 'hBF;
         v = $urandom;
         @(posedge mclk);
         tx_ev <= v[1:0];
         ev1 <= v[5:2];
         ev2 <= v[9:6];
         evv <= v[13:10];
         step();
         txp |= v[1:0];
         for (int p = 0; p < 4; p++)
            rxg[p] |= {v[10+p], v[6+p], v[2+p]};
         chkp();
         v = $urandom;
         HOST.clr(v[1:0], v[5:2], v[9:6], v[13:10]);
         txp &= ~int'(v[1:0]);
         for (int p = 0; p < 4; p++)
            rxg[p] &= ~int'({v[10+p], v[6+p], v[2+p]});
         chkp();
      end
      $display("test interrupt aggregation done");
      print_verdict();
   end
endmodule
